/* File: csf_core.sv */
/*
  status and mode bits, scaling shifters, accumulator and multiplier of a
  16-bit fixed-point core, driven over ahb-lite.
  assumes a single ahb-lite master with this slave alone on hready.
*/
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module csf_core (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // interrupt requests (asynchronous pins) and acknowledges
  input  wire logic        irq_req,
  input  wire logic        nmi_req,
  output logic             irq_ack,
  output logic             nmi_ack,
  // core side outputs
  output logic             external_flag_output,
  output logic      [15:0] dir_addr
);
  // bus state
  logic        wr_q, rd_q, rdy_q;
  logic        hresp_q;          // registered response, always okay
  logic [7:0]  adr_q;
  logic [31:0] rdat_q;
  // status and mode bits
  logic [8:0]  page_pointer_q, page_pointer_d;
  logic        global_irq_mask_q, global_irq_mask_d;
  logic        overflow_flag_q, overflow_flag_d;
  logic        overflow_saturate_mode_q, overflow_saturate_mode_d;
  logic [1:0]  product_shift_field_q, product_shift_field_d;
  logic        sign_extend_mode_q, sign_extend_mode_d;
  logic        test_control_flag_q, test_control_flag_d;
  logic        xf_q, xf_d;
  logic        brt_q, brt_d;
  // datapath registers
  logic [31:0] acc_q, acc_d;
  logic [31:0] product_register_q, product_register_d;
  logic [15:0] temporary_operand_register_q;
  logic [15:0] aux_register_zero_q;
  logic [15:0] daddr_q;
  // interrupt synchronisers and acknowledges
  logic        irq_m_q, irq_s_q, nmi_m_q, nmi_s_q, nmi_p_q;
  logic        irq_ack_q, nmi_ack_q;

  // address phase and command decode
  csf_pkg::csf_cmd_s cmd;
  wire addr_ph  = hsel & hready & htrans[1];
  wire exec     = wr_q & (adr_q == csf_pkg::A_CMD);
  wire w_temporary_operand_register   = wr_q & (adr_q == csf_pkg::A_TEMPORARY_OPERAND_REGISTER);
  wire w_ar0    = wr_q & (adr_q == csf_pkg::A_AR0);
  assign cmd    = csf_pkg::csf_cmd_s'(hwdata);
  wire [15:0] w = cmd.word;
  wire is_add_no_sign_ext_instr  = (cmd.op == csf_pkg::OP_ADD_NO_SIGN_EXT_INSTR);
  wire is_apac  = (cmd.op == csf_pkg::OP_APAC);

  // maskable trap only while mask is clear; nmi ignores the mask
  wire irq_take = irq_s_q & ~global_irq_mask_q & ~irq_ack_q;
  wire nmi_rise = nmi_s_q & ~nmi_p_q;

  // input scaling shifter, combinational in the operand path
  wire [4:0]  sh_raw = cmd.tsel ? {1'b0, temporary_operand_register_q[3:0]} : cmd.cnt;
  wire [4:0]  sh_cnt = (sh_raw > csf_pkg::MAX_SH) ? csf_pkg::MAX_SH : sh_raw;
  wire        sx_on  = sign_extend_mode_q & ~is_add_no_sign_ext_instr;
  wire [31:0] sh_in  = {{16{sx_on & w[15]}}, w};
  wire [31:0] isc    = sh_in << sh_cnt;

  // product scaling shifter; the product register itself is untouched
  logic [31:0] psc;
  always_comb begin
    case (product_shift_field_q)
      csf_pkg::PM_L1: psc = {product_register_q[30:0], 1'b0};
      csf_pkg::PM_L4: psc = {product_register_q[27:0], 4'h0};
      csf_pkg::PM_R6: psc = {{6{product_register_q[31]}}, product_register_q[31:6]};
      default:        psc = product_register_q;
    endcase
  end

  // central adder with overflow detection and optional saturation
  wire [31:0] add_b   = is_apac ? psc : isc;
  wire [32:0] add_sum = {acc_q[31], acc_q} + {add_b[31], add_b};
  wire        add_ov  = add_sum[32] ^ add_sum[31];
  wire [31:0] sat_val = add_sum[32] ? 32'h80000000 : 32'h7fffffff;
  wire [31:0] add_res = (add_ov & overflow_saturate_mode_q) ? sat_val : add_sum[31:0];

  // 16 by 16 signed multiplier
  wire signed [31:0] prod = $signed(temporary_operand_register_q) * $signed(w);

  // accumulator output shifter, left by the low bits of the temporary register
  wire [31:0] acc_sh = acc_q << temporary_operand_register_q[2:0];

  // bit test and compare conditions
  wire [3:0] bit_ix = 4'hf - temporary_operand_register_q[3:0];
  logic cmp_hit;
  always_comb begin
    case (cmd.sel[1:0])
      2'h0:    cmp_hit = (w == aux_register_zero_q);
      2'h1:    cmp_hit = (w <  aux_register_zero_q);
      2'h2:    cmp_hit = (w >  aux_register_zero_q);
      default: cmp_hit = (w != aux_register_zero_q);
    endcase
  end
  logic br_hit;
  always_comb begin
    case (cmd.sel[1:0])
      2'h0:    br_hit = overflow_flag_q;
      2'h1:    br_hit = ~overflow_flag_q;
      2'h2:    br_hit = test_control_flag_q;
      default: br_hit = ~test_control_flag_q;
    endcase
  end

  // next state of status bits and datapath registers
  always_comb begin
    page_pointer_d           = page_pointer_q;
    global_irq_mask_d        = global_irq_mask_q;
    overflow_flag_d          = overflow_flag_q;
    overflow_saturate_mode_d = overflow_saturate_mode_q;
    product_shift_field_d    = product_shift_field_q;
    sign_extend_mode_d       = sign_extend_mode_q;
    test_control_flag_d      = test_control_flag_q;
    xf_d                     = xf_q;
    brt_d                    = brt_q;
    acc_d                    = acc_q;
    product_register_d       = product_register_q;
    if (exec) begin
      case (cmd.op)
        // status zero load: mask bit deliberately left out
        csf_pkg::OP_LST0: begin
          page_pointer_d           = w[8:0];
          overflow_saturate_mode_d = w[csf_pkg::ST0_OVM];
          overflow_flag_d          = 1'b0;
        end
        // status one load
        csf_pkg::OP_LST1: begin
          product_shift_field_d = w[1:0];
          sign_extend_mode_d    = w[csf_pkg::ST1_SXM];
          test_control_flag_d   = w[csf_pkg::ST1_TC];
        end
        csf_pkg::OP_LDP: page_pointer_d = w[8:0];
        // set or clear one control bit
        csf_pkg::OP_SET_CONTROL_INSTR, csf_pkg::OP_CLEAR_CONTROL_INSTR: begin
          case (cmd.sel)
            csf_pkg::SEL_GLOBAL_IRQ_MASK: global_irq_mask_d = (cmd.op == csf_pkg::OP_SET_CONTROL_INSTR);
            csf_pkg::SEL_OVM:  overflow_saturate_mode_d = (cmd.op == csf_pkg::OP_SET_CONTROL_INSTR);
            csf_pkg::SEL_SXM:  sign_extend_mode_d = (cmd.op == csf_pkg::OP_SET_CONTROL_INSTR);
            csf_pkg::SEL_XF:   xf_d = (cmd.op == csf_pkg::OP_SET_CONTROL_INSTR);
            default: ;
          endcase
        end
        csf_pkg::OP_SPM: product_shift_field_d = cmd.sel[1:0];
        csf_pkg::OP_LAC: acc_d = isc;
        // additions latch overflow until explicitly cleared
        csf_pkg::OP_ADD, csf_pkg::OP_ADD_NO_SIGN_EXT_INSTR, csf_pkg::OP_APAC: begin
          acc_d = add_res;
          if (add_ov) overflow_flag_d = 1'b1;
        end
        csf_pkg::OP_MPY:  product_register_d = prod;
        csf_pkg::OP_BIT_TEST_DYNAMIC_INSTR: test_control_flag_d = w[bit_ix];
        csf_pkg::OP_AUX_COMPARE_INSTR: test_control_flag_d = cmp_hit;
        // normalize: flag on differing top bits, else shift left
        csf_pkg::OP_NORMALIZE_INSTR: begin
          test_control_flag_d = acc_q[31] ^ acc_q[30];
          if (!(acc_q[31] ^ acc_q[30])) acc_d = {acc_q[30:0], 1'b0};
        end
        // branch condition; testing overflow clears it
        csf_pkg::OP_CONDITIONAL_BRANCH_INSTR: begin
          brt_d = br_hit;
          if (!cmd.sel[1]) overflow_flag_d = 1'b0;
        end
        default: ;
      endcase
    end
    // a trap in the same cycle as a clear wins
    if (irq_take) global_irq_mask_d = 1'b1;
  end

  // status and datapath registers, visible to the next command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_pointer_q           <= csf_pkg::RST_DP;
      global_irq_mask_q        <= csf_pkg::RST_GLOBAL_IRQ_MASK;
      overflow_flag_q          <= 1'b0;
      overflow_saturate_mode_q <= 1'b0;
      product_shift_field_q    <= csf_pkg::RST_PM;
      sign_extend_mode_q       <= csf_pkg::RST_SXM;
      test_control_flag_q      <= 1'b0;
      xf_q                     <= csf_pkg::RST_XF;
      brt_q                    <= 1'b0;
      acc_q                    <= 32'h00000000;
      product_register_q       <= 32'h00000000;
    end else begin
      page_pointer_q           <= page_pointer_d;
      global_irq_mask_q        <= global_irq_mask_d;
      overflow_flag_q          <= overflow_flag_d;
      overflow_saturate_mode_q <= overflow_saturate_mode_d;
      product_shift_field_q    <= product_shift_field_d;
      sign_extend_mode_q       <= sign_extend_mode_d;
      test_control_flag_q      <= test_control_flag_d;
      xf_q                     <= xf_d;
      brt_q                    <= brt_d;
      acc_q                    <= acc_d;
      product_register_q       <= product_register_d;
    end
  end

  // operand registers and direct address capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temporary_operand_register_q <= 16'h0000;
      aux_register_zero_q          <= 16'h0000;
      daddr_q                      <= 16'h0000;
    end else begin
      if (w_temporary_operand_register) temporary_operand_register_q <= hwdata[15:0];
      if (w_ar0) aux_register_zero_q <= hwdata[15:0];
      if (exec) daddr_q <= {page_pointer_q, w[6:0]};
    end
  end

  // interrupt synchronisers and acknowledge pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {irq_m_q, irq_s_q, nmi_m_q, nmi_s_q, nmi_p_q} <= 5'h00;
      {irq_ack_q, nmi_ack_q}                        <= 2'h0;
    end else begin
      {irq_s_q, irq_m_q} <= {irq_m_q, irq_req};
      {nmi_p_q, nmi_s_q, nmi_m_q} <= {nmi_s_q, nmi_m_q, nmi_req};
      irq_ack_q <= irq_take;
      nmi_ack_q <= nmi_rise;
    end
  end

  // read multiplexer; reserved status bits read as ones
  wire [15:0] st0 = csf_pkg::ST0_ONES | {3'h0, overflow_flag_q, overflow_saturate_mode_q,
                    1'b0, global_irq_mask_q, page_pointer_q};
  wire [15:0] st1 = csf_pkg::ST1_ONES | {4'h0, test_control_flag_q, sign_extend_mode_q,
                    5'h00, xf_q, 1'b0, brt_q, product_shift_field_q};
  logic [31:0] rmux;
  always_comb begin
    case (adr_q)
      csf_pkg::A_ST0:  rmux = {16'h0000, st0};
      csf_pkg::A_ST1:  rmux = {16'h0000, st1};
      csf_pkg::A_ACC:  rmux = acc_q;
      csf_pkg::A_PRODUCT_REGISTER: rmux = product_register_q;
      csf_pkg::A_TEMPORARY_OPERAND_REGISTER: rmux = {16'h0000, temporary_operand_register_q};
      csf_pkg::A_AR0:  rmux = {16'h0000, aux_register_zero_q};
      csf_pkg::A_DADR: rmux = {16'h0000, daddr_q};
      csf_pkg::A_ISC:  rmux = isc;
      csf_pkg::A_PSC:  rmux = psc;
      csf_pkg::A_ACCH: rmux = {16'h0000, acc_sh[31:16]};
      default:         rmux = 32'h00000000;
    endcase
  end

  // bus slave: writes zero wait, reads one wait so data is current
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      rdy_q  <= 1'b1;
      hresp_q <= 1'b0;
      adr_q  <= 8'h00;
      rdat_q <= 32'h00000000;
    end else begin
      wr_q <= addr_ph & hwrite;
      rd_q <= addr_ph & ~hwrite;
      if (addr_ph) adr_q <= haddr[7:0];
      rdy_q <= ~(addr_ph & ~hwrite);
      hresp_q <= 1'b0; // no error responses are ever given
      if (rd_q) rdat_q <= rmux;
    end
  end

  // registered outputs
  assign hrdata               = rdat_q;
  assign hreadyout            = rdy_q;
  assign hresp                = hresp_q;
  assign irq_ack              = irq_ack_q;
  assign nmi_ack              = nmi_ack_q;
  assign external_flag_output = xf_q;
  assign dir_addr             = daddr_q;

  // checks
  wire ld_dp = exec & ((cmd.op == csf_pkg::OP_LDP) | (cmd.op == csf_pkg::OP_LST0));
  a_dp_load_only: assert property (@(posedge hclk) disable iff (!hresetn)
    !ld_dp |=> $stable(page_pointer_q)) else $error("page pointer moved without a load");
  a_daddr_form: assert property (@(posedge hclk) disable iff (!hresetn)
    exec |=> daddr_q == {$past(page_pointer_q), $past(w[6:0])}) else $error("direct address wrong");
  a_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_ack_q |-> !$past(global_irq_mask_q) && global_irq_mask_q) else $error("trap while masked");
  a_lst_keeps_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    exec && cmd.op == csf_pkg::OP_LST0 && !irq_take |=> $stable(global_irq_mask_q))
    else $error("status load touched mask");
  a_ov_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    overflow_flag_q && !(exec && (cmd.op == csf_pkg::OP_LST0 || cmd.op == csf_pkg::OP_CONDITIONAL_BRANCH_INSTR))
    |=> overflow_flag_q) else $error("overflow flag lost");
  a_psc_right6: assert property (@(posedge hclk) disable iff (!hresetn)
    product_shift_field_q == csf_pkg::PM_R6 |-> $signed(psc) == ($signed(product_register_q) >>> 6))
    else $error("right six product shift wrong");
  a_ov_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    exec && (cmd.op == csf_pkg::OP_ADD || is_add_no_sign_ext_instr || is_apac) && acc_q[31] == add_b[31] && add_sum[31] != acc_q[31]
    |=> overflow_flag_q) else $error("overflow not latched");
  a_add_no_sign_ext_instr_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    exec && is_add_no_sign_ext_instr |-> (isc >> sh_cnt) == {16'h0000, w}) else $error("add_no_sign_ext_instr sign extended");
  a_xf_set: assert property (@(posedge hclk) disable iff (!hresetn)
    exec && cmd.op == csf_pkg::OP_SET_CONTROL_INSTR && cmd.sel == csf_pkg::SEL_XF |=> external_flag_output)
    else $error("external flag not set");
  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ph && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
endmodule : csf_core

/* File: csf_pkg.sv */
/*
  shared constants and types of the status/mode bits and scaling shifter block.
  assumes an ahb-lite master with single word transfers and one core clock.
*/
package csf_pkg;
  // register byte offsets
  localparam logic [7:0] A_CMD  = 8'h00; // write issues one instruction
  localparam logic [7:0] A_ST0  = 8'h04; // status word zero
  localparam logic [7:0] A_ST1  = 8'h08; // status word one
  localparam logic [7:0] A_ACC  = 8'h0c; // accumulator
  localparam logic [7:0] A_PRODUCT_REGISTER = 8'h10; // product register
  localparam logic [7:0] A_TEMPORARY_OPERAND_REGISTER = 8'h14; // temporary operand register
  localparam logic [7:0] A_AR0  = 8'h18; // auxiliary register zero
  localparam logic [7:0] A_DADR = 8'h1c; // last direct address
  localparam logic [7:0] A_ISC  = 8'h20; // scaling shifter output
  localparam logic [7:0] A_PSC  = 8'h24; // product shifter output
  localparam logic [7:0] A_ACCH = 8'h28; // accumulator output shifter, high half
  // status word zero fields
  localparam int ST0_GLOBAL_IRQ_MASK = 9;
  localparam int ST0_OVM  = 11;
  localparam int ST0_OV   = 12;
  localparam logic [15:0] ST0_ONES = 16'he400; // reserved, read as one
  // status word one fields
  localparam int ST1_BRT  = 2;
  localparam int ST1_XF   = 4;
  localparam int ST1_SXM  = 10;
  localparam int ST1_TC   = 11;
  localparam logic [15:0] ST1_ONES = 16'hf3e8; // reserved, read as one
  // set/clear control selectors
  localparam logic [3:0] SEL_GLOBAL_IRQ_MASK = 4'h0;
  localparam logic [3:0] SEL_OVM  = 4'h1;
  localparam logic [3:0] SEL_SXM  = 4'h2;
  localparam logic [3:0] SEL_XF   = 4'h3;
  // product shift codes
  localparam logic [1:0] PM_NONE = 2'h0;
  localparam logic [1:0] PM_L1   = 2'h1;
  localparam logic [1:0] PM_L4   = 2'h2;
  localparam logic [1:0] PM_R6   = 2'h3;
  // reset values
  localparam logic [8:0] RST_DP   = 9'h000;
  localparam logic [1:0] RST_PM   = PM_NONE;
  localparam logic       RST_GLOBAL_IRQ_MASK = 1'b1;
  localparam logic       RST_SXM  = 1'b1;
  localparam logic       RST_XF   = 1'b1;
  localparam logic [4:0] MAX_SH   = 5'h10; // widest input scaling shift
  // instruction codes
  typedef enum logic [3:0] {
    OP_NOP, OP_LST0, OP_LST1, OP_LDP, OP_SET_CONTROL_INSTR, OP_CLEAR_CONTROL_INSTR, OP_SPM, OP_LAC,
    OP_ADD, OP_ADD_NO_SIGN_EXT_INSTR, OP_APAC, OP_MPY, OP_BIT_TEST_DYNAMIC_INSTR, OP_AUX_COMPARE_INSTR, OP_NORMALIZE_INSTR, OP_CONDITIONAL_BRANCH_INSTR
  } csf_op_e;
  // command word layout
  typedef struct packed {
    logic [15:0] word; // instruction word or data operand
    logic [1:0]  rsv;  // unused
    logic        tsel; // shift count from temporary register
    logic [4:0]  cnt;  // constant shift count
    logic [3:0]  sel;  // selector or condition
    csf_op_e     op;   // instruction
  } csf_cmd_s;
endpackage : csf_pkg

/* File: csf_host.sv */
/*
  host model: the instruction source that issues single-word ahb-lite
  transfers into the status/shifter block on behalf of the bench.
  assumes hready is the one slave's hreadyout and hclk runs free.
*/
`timescale 1ns/1ps
module csf_host (
  // bus clock
  input  wire logic        hclk,
  // master request
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  // slave answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // bus idle at time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // wait for a rising edge at which hready is sampled high
  task automatic wait_rdy;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : wait_rdy

  // one whole-word transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
    // released data bus must not keep showing the old word
    hwdata <= ~d;
  endtask : xfer
endmodule : csf_host

/* File: cpu_status_flags_and_scaling_shifter_tb.sv */
/*
  self-checking bench for the status/mode bits and scaling shifters.
  assumes csf_core as the only slave and csf_host as its bus master.
*/
`timescale 1ns/1ps
module cpu_status_flags_and_scaling_shifter_tb;
  logic        hclk = 1'b0;    // core clock
  logic        hresetn;        // async reset, active low
  logic        hsel;           // bus select
  logic [31:0] haddr;          // byte address
  logic [1:0]  htrans;         // transfer kind
  logic        hwrite;         // write strobe
  logic [2:0]  hsize;          // transfer size
  logic [31:0] hwdata;         // write data
  logic [31:0] hrdata;         // read data
  logic        hreadyout;      // slave ready, also bus hready
  logic        hresp;          // slave response
  logic        irq_req;        // maskable request
  logic        nmi_req;        // nonmaskable request
  logic        irq_ack;        // trap taken pulse
  logic        nmi_ack;        // nmi taken pulse
  logic        external_flag_output; // output pin
  logic [15:0] dir_addr;       // direct address
  int          n_fail;         // mismatches
  int          total_checks;   // comparisons made
  int          n_irq;          // maskable acks seen
  int          n_nmi;          // nmi acks seen
  int          cyc;            // cycle count for the hang guard

  always #5 hclk = ~hclk;

  csf_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req), .nmi_req(nmi_req), .irq_ack(irq_ack),
    .nmi_ack(nmi_ack), .external_flag_output(external_flag_output), .dir_addr(dir_addr));
  csf_host i_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  // count ack pulses and guard against a hang
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (irq_ack === 1'b1) n_irq <= n_irq + 1;
    if (nmi_ack === 1'b1) n_nmi <= n_nmi + 1;
    if (cyc == 8000) begin
      n_fail++;
      final_report;
    end
  end

  // compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // bus helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    i_host.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    check(q, e);
  endtask : rdc
  task automatic rb(input logic [7:0] a, input int b, input logic e);
    logic [31:0] q;
    rd(a, q);
    check({31'h0, q[b]}, {31'h0, e});
  endtask : rb
  // issue one instruction through the command word
  task automatic ex(input csf_pkg::csf_op_e op, input logic [3:0] s = 4'h0, input logic [15:0] w = 16'h0,
                    input logic [4:0] n = 5'h0, input logic t = 1'b0);
    csf_pkg::csf_cmd_s c;
    c = '{word: w, rsv: 2'h0, tsel: t, cnt: n, sel: s, op: op};
    wr(csf_pkg::A_CMD, c);
  endtask : ex

  // reset values, reserved ones, unmapped read
  task automatic t_reset;
    rdc(csf_pkg::A_ST0, 32'h0000e600);
    rdc(csf_pkg::A_ST1, 32'h0000f7f8);
    check({31'h0, external_flag_output}, 32'h1);
    check({31'h0, hresp}, 32'h0);
    rdc(8'h3c, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // direct address and page pointer stability
  task automatic t_page;
    ex(csf_pkg::OP_LDP, 4'h0, 16'h01a5);
    ex(csf_pkg::OP_NOP, 4'h0, 16'h00ff);
    @(negedge hclk);
    check({16'h0, dir_addr}, {16'h0, 9'h1a5, 7'h7f});
    ex(csf_pkg::OP_SET_CONTROL_INSTR, csf_pkg::SEL_OVM, 16'hffff);
    ex(csf_pkg::OP_CLEAR_CONTROL_INSTR, csf_pkg::SEL_OVM, 16'hffff);
    rdc(csf_pkg::A_ST0, 32'h0000e7a5);
    $display("test page done");
  endtask : t_page

  // every set/clear selector, both ways
  task automatic t_setclr;
    int bt[4] = '{csf_pkg::ST0_GLOBAL_IRQ_MASK, csf_pkg::ST0_OVM, csf_pkg::ST1_SXM, csf_pkg::ST1_XF};
    for (int s = 0; s < 4; s++) begin
      ex(csf_pkg::OP_CLEAR_CONTROL_INSTR, 4'(s));
      rb(s < 2 ? csf_pkg::A_ST0 : csf_pkg::A_ST1, bt[s], 1'b0);
      ex(csf_pkg::OP_SET_CONTROL_INSTR, 4'(s));
      rb(s < 2 ? csf_pkg::A_ST0 : csf_pkg::A_ST1, bt[s], 1'b1);
    end
    ex(csf_pkg::OP_CLEAR_CONTROL_INSTR, csf_pkg::SEL_XF);
    @(negedge hclk);
    check({31'h0, external_flag_output}, 32'h0);
    ex(csf_pkg::OP_SET_CONTROL_INSTR, csf_pkg::SEL_XF);
    $display("test set/clear done");
  endtask : t_setclr

  // status loads keep the mask, load modes and fields
  task automatic t_lst;
    ex(csf_pkg::OP_CLEAR_CONTROL_INSTR, csf_pkg::SEL_GLOBAL_IRQ_MASK);
    ex(csf_pkg::OP_LST0, 4'h0, 16'h0a12);
    rdc(csf_pkg::A_ST0, 32'h0000ec12);
    ex(csf_pkg::OP_LST1, 4'h0, 16'h0802);
    rdc(csf_pkg::A_ST1, 32'h0000fbfa);
    ex(csf_pkg::OP_SET_CONTROL_INSTR, csf_pkg::SEL_GLOBAL_IRQ_MASK);
    ex(csf_pkg::OP_SET_CONTROL_INSTR, csf_pkg::SEL_SXM);
    ex(csf_pkg::OP_SPM, 4'h0);
    $display("test status load done");
  endtask : t_lst

  // sticky overflow, wrap and saturate, the three clears
  task automatic t_ovf;
    ex(csf_pkg::OP_CLEAR_CONTROL_INSTR, csf_pkg::SEL_OVM);
    ex(csf_pkg::OP_LAC, 4'h0, 16'h7fff, 5'h10);
    ex(csf_pkg::OP_ADD, 4'h0, 16'h7fff, 5'h10);
    rdc(csf_pkg::A_ACC, 32'hfffe0000);
    rb(csf_pkg::A_ST0, csf_pkg::ST0_OV, 1'b1);
    ex(csf_pkg::OP_CONDITIONAL_BRANCH_INSTR, 4'h2);
    ex(csf_pkg::OP_NOP);
    rb(csf_pkg::A_ST0, csf_pkg::ST0_OV, 1'b1);
    ex(csf_pkg::OP_CONDITIONAL_BRANCH_INSTR, 4'h1);
    rb(csf_pkg::A_ST0, csf_pkg::ST0_OV, 1'b0);
    ex(csf_pkg::OP_SET_CONTROL_INSTR, csf_pkg::SEL_OVM);
    ex(csf_pkg::OP_LAC, 4'h0, 16'h7fff, 5'h10);
    ex(csf_pkg::OP_ADD, 4'h0, 16'h7fff, 5'h10);
    rdc(csf_pkg::A_ACC, 32'h7fffffff);
    rb(csf_pkg::A_ST0, csf_pkg::ST0_OV, 1'b1);
    ex(csf_pkg::OP_CONDITIONAL_BRANCH_INSTR, 4'h0);
    rb(csf_pkg::A_ST1, csf_pkg::ST1_BRT, 1'b1);
    rb(csf_pkg::A_ST0, csf_pkg::ST0_OV, 1'b0);
    ex(csf_pkg::OP_ADD, 4'h0, 16'h7fff, 5'h10);
    rb(csf_pkg::A_ST0, csf_pkg::ST0_OV, 1'b1);
    ex(csf_pkg::OP_LST0, 4'h0, 16'h0000);
    rb(csf_pkg::A_ST0, csf_pkg::ST0_OV, 1'b0);
    $display("test overflow done");
  endtask : t_ovf

  // input scaler: fill modes, boundary count, register count
  task automatic t_scale;
    ex(csf_pkg::OP_LAC, 4'h0, 16'h8001, 5'h4);
    rdc(csf_pkg::A_ACC, 32'hfff80010);
    ex(csf_pkg::OP_LAC, 4'h0, 16'h8001, 5'h10);
    rdc(csf_pkg::A_ACC, 32'h80010000);
    ex(csf_pkg::OP_LAC);
    ex(csf_pkg::OP_ADD_NO_SIGN_EXT_INSTR, 4'h0, 16'h8001);
    rdc(csf_pkg::A_ACC, 32'h00008001);
    wr(csf_pkg::A_TEMPORARY_OPERAND_REGISTER, 32'h3);
    ex(csf_pkg::OP_LAC, 4'h0, 16'h0001, 5'h0, 1'b1);
    rdc(csf_pkg::A_ACC, 32'h00000008);
    ex(csf_pkg::OP_CLEAR_CONTROL_INSTR, csf_pkg::SEL_SXM);
    ex(csf_pkg::OP_LAC, 4'h0, 16'h8001, 5'h4);
    rdc(csf_pkg::A_ACC, 32'h00080010);
    ex(csf_pkg::OP_SET_CONTROL_INSTR, csf_pkg::SEL_SXM);
    $display("test scaler done");
  endtask : t_scale

  // every product shift code, product register untouched
  task automatic t_prod;
    logic [31:0] pe[4] = '{32'hfffffffa, 32'hfffffff4, 32'hffffffa0, 32'hffffffff};
    wr(csf_pkg::A_TEMPORARY_OPERAND_REGISTER, 32'h3);
    ex(csf_pkg::OP_MPY, 4'h0, 16'hfffe);
    for (int m = 0; m < 4; m++) begin
      ex(csf_pkg::OP_SPM, 4'(m));
      ex(csf_pkg::OP_LAC);
      ex(csf_pkg::OP_APAC);
      rdc(csf_pkg::A_ACC, pe[m]);
      rdc(csf_pkg::A_PRODUCT_REGISTER, 32'hfffffffa);
    end
    ex(csf_pkg::OP_SPM, 4'h0);
    $display("test product done");
  endtask : t_prod

  // test flag sources and branches on it
  task automatic t_tc;
    logic [15:0] cw[4] = '{16'h5, 16'h5, 16'h5, 16'h6};
    wr(csf_pkg::A_TEMPORARY_OPERAND_REGISTER, 32'h0);
    ex(csf_pkg::OP_BIT_TEST_DYNAMIC_INSTR, 4'h0, 16'h8000);
    rb(csf_pkg::A_ST1, csf_pkg::ST1_TC, 1'b1);
    ex(csf_pkg::OP_BIT_TEST_DYNAMIC_INSTR, 4'h0, 16'h7fff);
    rb(csf_pkg::A_ST1, csf_pkg::ST1_TC, 1'b0);
    wr(csf_pkg::A_AR0, 32'h5);
    for (int c = 0; c < 4; c++) begin
      ex(csf_pkg::OP_AUX_COMPARE_INSTR, 4'(c), cw[c]);
      rb(csf_pkg::A_ST1, csf_pkg::ST1_TC, c == 0 || c == 3);
    end
    ex(csf_pkg::OP_LAC, 4'h0, 16'h4000, 5'h10);
    ex(csf_pkg::OP_NORMALIZE_INSTR);
    rb(csf_pkg::A_ST1, csf_pkg::ST1_TC, 1'b1);
    ex(csf_pkg::OP_CONDITIONAL_BRANCH_INSTR, 4'h2);
    rb(csf_pkg::A_ST1, csf_pkg::ST1_BRT, 1'b1);
    ex(csf_pkg::OP_CONDITIONAL_BRANCH_INSTR, 4'h3);
    rb(csf_pkg::A_ST1, csf_pkg::ST1_BRT, 1'b0);
    $display("test flag done");
  endtask : t_tc

  // one trap while unmasked, then blocked by the forced mask; nmi always
  task automatic t_irq;
    int n0;
    ex(csf_pkg::OP_CLEAR_CONTROL_INSTR, csf_pkg::SEL_GLOBAL_IRQ_MASK);
    n0 = n_irq;
    irq_req <= 1'b1;
    repeat (12) @(posedge hclk);
    check(32'(n_irq - n0), 32'h1);
    rb(csf_pkg::A_ST0, csf_pkg::ST0_GLOBAL_IRQ_MASK, 1'b1);
    n0 = n_nmi;
    nmi_req <= 1'b1;
    repeat (12) @(posedge hclk);
    check(32'(n_nmi - n0), 32'h1);
    irq_req <= 1'b0;
    nmi_req <= 1'b0;
    $display("test interrupt done");
  endtask : t_irq

  // counts and verdict
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    hresetn = 1'b0;
    irq_req = 1'b0;
    nmi_req = 1'b0;
    n_fail = 0;
    total_checks = 0;
    n_irq = 0;
    n_nmi = 0;
    cyc = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_page;
    t_setclr;
    t_lst;
    t_ovf;
    t_scale;
    t_prod;
    t_tc;
    t_irq;
    final_report;
  end
endmodule : cpu_status_flags_and_scaling_shifter_tb
